// File: rtl/tpc_pkg.sv
// Package for the transmitter phase code sequencer.
// Assumes a single 200 MHz clock domain shared by all users.
//
// Behaviour
// - Output pseudo-random 8-bit codes from enabled set
// - Random codes only in random-phase modes
// - Otherwise hold configurable idle code, default 00
// - Idle code bypasses the enable table
// - One enable flag per code, 256 total
package tpc_pkg;

  localparam int unsigned CODE_W     = 8;
  localparam int unsigned CODE_NUM   = 256;
  localparam int unsigned ROW_W      = 16;
  localparam int unsigned ROW_NUM    = 16;
  localparam logic [7:0]  IDLE_RST   = 8'h00;
  localparam logic [15:0] LFSR_SEED  = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS  = 16'hB400;

  typedef enum logic [1:0] {
    MODE_OTHER  = 2'h0,
    MODE_RND_TS = 2'h1,
    MODE_RND_PP = 2'h2
  } tpc_mode_t;

  // Processor-side controls travelling together
  typedef struct packed {
    tpc_mode_t        mode;
    logic             pulse;
    logic [7:0]       idle_code;
  } tpc_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HUNT = 3'b010,
    ST_HOLD = 3'b100
  } tpc_state_t;

endpackage : tpc_pkg

// File: rtl/tpc_lfsr.sv
// Galois LFSR, steps once per cycle while enabled.
// Assumes clk_i and nrst_i of the sequencer domain.
`timescale 1ns/1ps
module tpc_lfsr (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        step_i,
  output logic [7:0]       rnd_o
);
  logic [15:0] lfsr_reg;
  logic [15:0] lfsr_next;

  always_comb begin
    lfsr_next = lfsr_reg;
    if (step_i) begin
      lfsr_next = {1'b0, lfsr_reg[15:1]};
      if (lfsr_reg[0]) begin
        lfsr_next = lfsr_next ^ tpc_pkg::LFSR_TAPS;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lfsr_reg <= tpc_pkg::LFSR_SEED;
    end else begin
      lfsr_reg <= lfsr_next;
    end
  end

  assign rnd_o = lfsr_reg[7:0];
endmodule : tpc_lfsr

// File: rtl/tpc_seq.sv
// Phase code sequencer top: picks enabled random codes per pulse.
// Assumes mode, pulse strobe and table come synchronous to clk_i.
`timescale 1ns/1ps
module tpc_seq (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire tpc_pkg::tpc_ctrl_t ctrl_i,
  input  wire logic [255:0]      code_en_i,
  output logic [7:0]             phase_o,
  output logic                   phase_vld_o,
  output logic                   no_code_o
);
  tpc_pkg::tpc_state_t state_reg;
  tpc_pkg::tpc_state_t state_next;
  logic [7:0]          phase_reg;
  logic [7:0]          phase_next;
  logic [7:0]          rnd;
  logic                rnd_mode;
  logic                any_en;
  logic [15:0]         row_any;
  logic [3:0]          cand_row;
  logic [3:0]          cand_col;
  logic [15:0]         cand_row_bits;
  logic                cand_ok;
  logic                enter_rnd;
  logic                leave_rnd;
  logic                idle_st;
  logic                hold_st;

  // Mode 3 is unused and treated like any non-random mode
  always_comb begin
    case (ctrl_i.mode)
      tpc_pkg::MODE_RND_TS: begin
        rnd_mode = 1'b1;
      end
      tpc_pkg::MODE_RND_PP: begin
        rnd_mode = 1'b1;
      end
      tpc_pkg::MODE_OTHER: begin
        rnd_mode = 1'b0;
      end
      default: begin
        rnd_mode = 1'b0;
      end
    endcase
  end

  // Table held as sixteen rows of sixteen flags
  for (genvar g = 0; g < tpc_pkg::ROW_NUM; g++) begin : g_row
    assign row_any[g] = |code_en_i[g*tpc_pkg::ROW_W +: tpc_pkg::ROW_W];
  end

  assign any_en = |row_any;

  tpc_lfsr u_lfsr (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .step_i (1'b1),
    .rnd_o  (rnd)
  );

  // Candidate looked up by row, then by column
  assign cand_row = rnd[7:4];
  assign cand_col = rnd[3:0];

  always_comb begin
    cand_row_bits = '0;
    for (int ri = 0; ri < tpc_pkg::ROW_NUM; ri++) begin
      if (cand_row == 4'(ri)) begin
        cand_row_bits = code_en_i[ri*tpc_pkg::ROW_W +: tpc_pkg::ROW_W];
      end
    end
  end

  assign cand_ok = cand_row_bits[cand_col];

  // Empty table in random mode falls back to the idle code
  assign enter_rnd = rnd_mode && any_en;
  assign leave_rnd = !rnd_mode || !any_en;

  // Random candidate tried every cycle until an enabled one appears;
  // a sparse table costs latency, never a disabled code.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tpc_pkg::ST_IDLE: begin
        if (enter_rnd) begin
          state_next = tpc_pkg::ST_HUNT;
        end
      end
      tpc_pkg::ST_HUNT: begin
        if (leave_rnd) begin
          state_next = tpc_pkg::ST_IDLE;
        end else if (cand_ok) begin
          state_next = tpc_pkg::ST_HOLD;
        end
      end
      tpc_pkg::ST_HOLD: begin
        if (leave_rnd) begin
          state_next = tpc_pkg::ST_IDLE;
        end else if (ctrl_i.pulse) begin
          state_next = tpc_pkg::ST_HUNT;
        end
      end
      default: begin
        state_next = tpc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= tpc_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Old code kept while hunting, so the modulator never sees a gap
  always_comb begin
    phase_next = phase_reg;
    case (state_reg)
      tpc_pkg::ST_IDLE: begin
        phase_next = ctrl_i.idle_code;
      end
      tpc_pkg::ST_HUNT: begin
        if (leave_rnd) begin
          phase_next = ctrl_i.idle_code;
        end else if (cand_ok) begin
          phase_next = rnd;
        end
      end
      tpc_pkg::ST_HOLD: begin
        if (leave_rnd) begin
          phase_next = ctrl_i.idle_code;
        end
      end
      default: begin
        phase_next = ctrl_i.idle_code;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_reg <= tpc_pkg::IDLE_RST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign idle_st     = (state_reg == tpc_pkg::ST_IDLE);
  assign hold_st     = (state_reg == tpc_pkg::ST_HOLD);
  assign phase_o     = phase_reg;
  assign phase_vld_o = hold_st || idle_st;
  assign no_code_o   = rnd_mode && !any_en;
endmodule : tpc_seq

// File: sim/tpc_seq_asserts.sv
// Checker for the phase code sequencer, bound to its top.
// Assumes the table and idle code only change outside random modes.
`timescale 1ns/1ps
module tpc_seq_asserts (
  input wire logic               clk_i,
  input wire logic               nrst_i,
  input wire tpc_pkg::tpc_ctrl_t ctrl_i,
  input wire logic [255:0]       code_en_i,
  input wire logic [7:0]         phase_o,
  input wire logic               phase_vld_o,
  input wire logic               no_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Mode 3 reduces to zero, like mode 0
  wire r = ^ctrl_i.mode;
  chk_idle_out: assert property (!$past(r) |->
    phase_o == $past(ctrl_i.idle_code)) else $error("idle code wrong");
  chk_code_legal: assert property ($past(r) && r && phase_vld_o &&
    !no_code_o |-> code_en_i[phase_o]) else $error("code not enabled");
  chk_hold_stable: assert property ($past(r) && r && phase_vld_o &&
    $past(phase_vld_o) && !$past(ctrl_i.pulse) |-> $stable(phase_o))
    else $error("held code moved");
  chk_pulse_rehunt: assert property ($past(r) && r && phase_vld_o &&
    $past(phase_vld_o) && !no_code_o && ctrl_i.pulse |=> !phase_vld_o)
    else $error("pulse ignored");
  chk_empty_flag: assert property ($past(r) && r &&
    $past(code_en_i) == 0 && code_en_i == 0 |-> no_code_o)
    else $error("empty table not flagged");
  chk_full_fast: assert property (r && &code_en_i &&
    !phase_vld_o |=> phase_vld_o) else $error("hunt too slow");
endmodule : tpc_seq_asserts
bind tpc_seq tpc_seq_asserts i_chk (.clk_i, .nrst_i, .ctrl_i, .code_en_i,
  .phase_o, .phase_vld_o, .no_code_o);

// File: sim/tpc_mod.sv
// Phase modulator model: latches the code each clock.
// Assumes codes arrive registered on clk_i.
`timescale 1ns/1ps
module tpc_mod (
  input  wire logic       clk_i,
  input  wire logic [7:0] phase_i,
  output logic      [7:0] phase_o
);
  always_ff @(posedge clk_i) phase_o <= phase_i;
endmodule : tpc_mod

// File: sim/tb_top.sv
// Self-checking bench for the phase code sequencer.
// Assumes the checker binds itself to the sequencer.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, nrst_i = 0, vld, nc;
  tpc_pkg::tpc_ctrl_t c = '0;
  logic [255:0] en = '0;
  logic [7:0]   ph, mod, held;
  int n_errors = 0, n_compared = 0;
  tpc_seq i_dut (.clk_i, .nrst_i, .ctrl_i(c), .code_en_i(en), .phase_o(ph),
    .phase_vld_o(vld), .no_code_o(nc));
  tpc_mod i_mod (.clk_i, .phase_i(ph), .phase_o(mod));
  initial forever #2.5 clk_i = ~clk_i;
  task cyc; @(posedge clk_i) #1; endtask : cyc
  task chk(logic [7:0] s, logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  function logic [7:0] ok(logic [7:0] p); return {7'h0, en[p]}; endfunction
  task tally_and_finish;
    $display("n_errors=%0d n_compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin #200000; n_errors++; tally_and_finish; end
  initial begin
    void'($urandom(56338));
    repeat (2) cyc;
    nrst_i = 1;
    for (int i = 0; i < 48; i++) begin
      // Table changes only with random mode off
      c = '0;
      c.idle_code = 8'($urandom);
      en = i % 6 ? {8{$urandom}} : '0;
      if (i % 6 == 1) en = '1;
      cyc;
      chk(ph, c.idle_code);
      cyc;
      chk(ph, c.idle_code);
      chk(mod, c.idle_code);
      c.mode = tpc_pkg::tpc_mode_t'(i % 4);
      repeat (3) begin
        c.pulse = 1;
        cyc;
        c.pulse = 0;
        for (int k = 0; k < 999 && vld !== 1; k++) cyc;
        if (^c.mode && en != 0) chk(ok(ph), 8'h01);
        else chk(ph, c.idle_code);
        chk({7'h0, vld}, 8'h01);
        chk({7'h0, nc}, {7'h0, ^c.mode && en == 0});
        held = ph;
        repeat (2) cyc;
        chk(ph, held);
      end
    end
    tally_and_finish;
  end
endmodule : tb_top
